// ### hrsp_consts.svh
/*
 * Constants of the host register serial port: frame layout, address fields,
 * register reset values and the speed limits the host keeps.
 * Assumes it is included by its bare name from design files only.
 */
`ifndef HRSP_CONSTS_SVH
`define HRSP_CONSTS_SVH

// Register file shape.
`define HRSP_IDX_W        5
`define HRSP_NUM_REGS     32

// Four-wire frame: chip code, direction, index, data byte.
`define HRSP_CHIP_CODE    2'h0
`define HRSP_DIR_READ     1'b0
`define HRSP_DIR_WRITE    1'b1
`define HRSP_HDR_BITS     5'h08
`define HRSP_LAST_BIT     5'h0F
`define HRSP_FRAME_BITS   5'h10

// Two-wire slave address upper bits and direction code.
`define HRSP_SLAVE_HI     5'h04
`define HRSP_I2C_READ     1'b1
`define HRSP_BYTE_BITS    4'h8
`define HRSP_TX_LAST      4'h7

// Register reset values.
`define HRSP_DEF_00       8'h43
`define HRSP_DEF_01       8'h6A
`define HRSP_DEF_02       8'h88
`define HRSP_DEF_03       8'h48
`define HRSP_DEF_04       8'hEE
`define HRSP_DEF_OTHER    8'h00

// Host-side speed limits in Hz.
`define HRSP_SHIFT_CLK_MAX_HZ 5000000
`define HRSP_I2C_CLK_MAX_HZ   100000

`endif

// ### hrsp_pkg.sv
/*
 * Types shared by the host register serial port.
 * Assumes nothing of its surroundings.
 */
package hrsp_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } hrsp_i2c_state_type;

    typedef enum logic [1:0] {
        PH_ADDR  = 2'h0,
        PH_INDEX = 2'h1,
        PH_DATA  = 2'h2
    } hrsp_phase_type;

endpackage

// ### hrsp_sync.sv
/*
 * Two-flop synchroniser bank for pins arriving from outside the clock domain.
 * Assumes each bit is an independent level; no bus coherence is offered.
 */
`timescale 1ns/100ps
module hrsp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and control.
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // Data.
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    generate
        if (WIDTH < 1) begin : g_bad
            $error("hrsp_sync needs WIDTH of at least one");
        end
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // Idle pins float high, so the flops start high.
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                end else if (ce_i) begin
                    meta_r <= d_i[i];
                    sync_r <= meta_r;
                end
            end
            assign q_o[i] = sync_r;
        end
    endgenerate

endmodule // hrsp_sync

// ### hrsp_top.sv
/*
 * Host register serial port: 32 byte-wide registers reached either over a
 * four-wire shifted port or as a standard-mode two-wire bus slave.
 * Assumes all pins are asynchronous and slow against MCLK_I (100 MHz), and
 * that the rest of the device watches the registered write strobe.
 */
// Functional notes
// - Strap low selects four-wire port, high selects two-wire slave.
// - Four-wire frame: two zero code bits, direction, 5-bit index, data byte.
// - Four-wire direction bit zero reads, one writes.
// - Four-wire input sampled on rising clock, output changed on falling.
// - Four-wire write commits after sixteenth rising edge after select falls.
// - Four-wire output released once select returns high.
// - Power-down pin low returns all registers to defaults.
// - Data only changes while clock low, except START and STOP.
// - START is data falling with clock high; STOP data rising.
// - First byte matches 00100 plus two straps; LSB one means read.
// - Addressed device holds data low through ninth clock high.
// - Write byte after address sets index; top three bits ignored.
// - Each written byte advances 5-bit counter, wrapping 1F to 00.
// - Counter holds last accessed address plus one, reads and writes.
// - Read sends eight bits, releases, samples ack; no ack ends.
// - Current read sends byte at counter then advances counter.
`timescale 1ns/100ps
module hrsp_top
    import hrsp_pkg::*;
(
    // Clock, reset, enable.
    input  wire logic       MCLK_I,
    input  wire logic       RST_I,
    input  wire logic       CE_I,
    // Straps and power-down.
    input  wire logic       BUS_STYLE_SELECT_I,
    input  wire logic       POWER_DOWN_LOW_N_I,
    input  wire logic       DEV_ADDR_STRAP_HI_I,
    input  wire logic       DEV_ADDR_STRAP_LO_I,
    // Four-wire port.
    input  wire logic       CHIP_SELECT_LOW_N_I,
    input  wire logic       CONTROL_SHIFT_CLOCK_I,
    input  wire logic       CONTROL_SERIAL_IN_I,
    output logic            CONTROL_SERIAL_OUT_O,
    output logic            CONTROL_SERIAL_OUT_OE_O,
    // Two-wire port.
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_O,
    // Register write notice to the device.
    output logic            REG_WR_O,
    output logic [4:0]      REG_IDX_O,
    output logic [7:0]      REG_DATA_O
);

    `include "hrsp_consts.svh"

    function automatic logic [7:0] reg_default(input int unsigned i);
        case (i)
            0: reg_default = `HRSP_DEF_00;
            1: reg_default = `HRSP_DEF_01;
            2: reg_default = `HRSP_DEF_02;
            3: reg_default = `HRSP_DEF_03;
            4: reg_default = `HRSP_DEF_04;
            default: reg_default = `HRSP_DEF_OTHER;
        endcase
    endfunction

    logic [8:0]              pins_s;
    logic                    strap_s;
    logic                    pdn_n_s;
    logic                    cs_n_s;
    logic                    sclk_s;
    logic                    sdi_s;
    logic                    scl_s;
    logic                    sda_s;
    logic                    cad_hi_s;
    logic                    cad_lo_s;

    hrsp_sync #(
        .WIDTH (9)
    ) u_sync (
        .clk_i (MCLK_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .d_i   ({BUS_STYLE_SELECT_I, POWER_DOWN_LOW_N_I, CHIP_SELECT_LOW_N_I,
                 CONTROL_SHIFT_CLOCK_I, CONTROL_SERIAL_IN_I, SCL_I, SDA_I,
                 DEV_ADDR_STRAP_HI_I, DEV_ADDR_STRAP_LO_I}),
        .q_o   (pins_s)
    );

    assign {strap_s, pdn_n_s, cs_n_s, sclk_s, sdi_s, scl_s, sda_s,
            cad_hi_s, cad_lo_s} = pins_s;

    logic [7:0]              regs_r [`HRSP_NUM_REGS];
    logic                    mode_r;
    logic [2:0]              mode_ok_r;
    logic                    sclk_p_r;
    logic                    scl_p_r;
    logic                    sda_p_r;

    // strap capture.
    // The strap is only taken in power-down or right after reset, so a stray
    // level change mid-transfer cannot flip the port under the host.
    // The synchroniser shows its reset level for two edges, so the strap is
    // taken over the first three edges and the last one holds the real pin.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_r    <= 1'b0;
            mode_ok_r <= 3'h0;
        end else if (CE_I) begin
            mode_ok_r <= {mode_ok_r[1:0], 1'b1};
            if (!pdn_n_s || !mode_ok_r[2]) begin
                mode_r <= strap_s;
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            sclk_p_r <= 1'b0;
            scl_p_r  <= 1'b1;
            sda_p_r  <= 1'b1;
        end else if (CE_I) begin
            sclk_p_r <= sclk_s;
            scl_p_r  <= scl_s;
            sda_p_r  <= sda_s;
        end
    end

    // Four-wire port.
    logic [4:0]              cnt4_r;
    logic [14:0]             sh4_r;
    logic [6:0]              out4_r;
    logic                    control_serial_out_r;
    logic                    control_serial_out_oe_r;
    logic                    rise4;
    logic                    fall4;
    logic                    w4_en;
    logic                    rd4_go;

    assign rise4 = !mode_r && pdn_n_s && !cs_n_s && sclk_s && !sclk_p_r;
    assign fall4 = !mode_r && pdn_n_s && !cs_n_s && !sclk_s && sclk_p_r;

    assign w4_en = rise4 && cnt4_r == `HRSP_LAST_BIT &&
                   sh4_r[14:13] == `HRSP_CHIP_CODE && sh4_r[12] == `HRSP_DIR_WRITE;
    assign rd4_go = fall4 && cnt4_r == `HRSP_HDR_BITS &&
                    sh4_r[7:6] == `HRSP_CHIP_CODE && sh4_r[5] == `HRSP_DIR_READ;

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt4_r <= 5'h00;
            sh4_r  <= 15'h0000;
        end else if (CE_I) begin
            if (cs_n_s || mode_r || !pdn_n_s) begin
                cnt4_r <= 5'h00;
            end else if (rise4 && cnt4_r != `HRSP_FRAME_BITS) begin
                cnt4_r <= cnt4_r + 5'h01;
                sh4_r  <= {sh4_r[13:0], sdi_s};
            end
        end
    end

    // read byte in final eight periods.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            control_serial_out_r    <= 1'b0;
            control_serial_out_oe_r <= 1'b0;
            out4_r    <= 7'h00;
        end else if (CE_I) begin
            if (cs_n_s || mode_r || !pdn_n_s) begin
                control_serial_out_oe_r <= 1'b0;
            end else if (rd4_go) begin
                control_serial_out_r    <= regs_r[sh4_r[4:0]][7];
                out4_r    <= regs_r[sh4_r[4:0]][6:0];
                control_serial_out_oe_r <= 1'b1;
            end else if (fall4 && control_serial_out_oe_r && cnt4_r < `HRSP_FRAME_BITS) begin
                control_serial_out_r <= out4_r[6];
                out4_r <= {out4_r[5:0], 1'b0};
            end
        end
    end

    // Two-wire port.
    hrsp_i2c_state_type      st_r;
    hrsp_phase_type          phase_r;
    logic [3:0]              bit_r;
    logic [7:0]              rx_r;
    logic [6:0]              tx_r;
    logic                    rw_r;
    logic                    ackd_r;
    logic                    sda_oe_r;
    logic [4:0]              ptr_r;
    logic                    start_ev;
    logic                    stop_ev;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    byte_done;
    logic                    addr_hit;
    logic                    tx_load;
    logic                    w2_en;
    logic                    idx_set;

    // data edges with clock high are conditions, never data.
    assign start_ev = mode_r && pdn_n_s && scl_s && scl_p_r && !sda_s && sda_p_r;
    assign stop_ev  = mode_r && pdn_n_s && scl_s && scl_p_r && sda_s && !sda_p_r;
    assign scl_rise = mode_r && pdn_n_s && scl_s && !scl_p_r;
    assign scl_fall = mode_r && pdn_n_s && !scl_s && scl_p_r;
    assign byte_done = st_r == ST_RX && scl_fall && bit_r == `HRSP_BYTE_BITS;
    assign addr_hit = rx_r[7:1] == {`HRSP_SLAVE_HI, cad_hi_s, cad_lo_s};
    // byte at counter is loaded on these edges.
    assign tx_load = scl_fall && ((st_r == ST_ACK && rw_r == `HRSP_I2C_READ) ||
                                  (st_r == ST_MACK && ackd_r));
    assign idx_set = byte_done && phase_r == PH_INDEX;
    assign w2_en   = byte_done && phase_r == PH_DATA;

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_r     <= ST_IDLE;
            phase_r  <= PH_ADDR;
            bit_r    <= 4'h0;
            rx_r     <= 8'h00;
            tx_r     <= 7'h00;
            rw_r     <= 1'b0;
            ackd_r   <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (CE_I) begin
            if (!mode_r || !pdn_n_s) begin
                st_r     <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end else if (start_ev) begin
                st_r     <= ST_RX;
                phase_r  <= PH_ADDR;
                bit_r    <= 4'h0;
                sda_oe_r <= 1'b0;
            end else if (stop_ev) begin
                st_r     <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end else begin
                case (st_r)
                    ST_RX: begin
                        if (scl_rise) begin
                            rx_r  <= {rx_r[6:0], sda_s};
                            bit_r <= bit_r + 4'h1;
                        end else if (byte_done) begin
                            if (phase_r != PH_ADDR || addr_hit) begin
                                sda_oe_r <= 1'b1;
                                st_r     <= ST_ACK;
                                if (phase_r == PH_ADDR) begin
                                    rw_r <= rx_r[0];
                                end
                            end else begin
                                // not ours, stay off the bus.
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_r   <= 4'h0;
                            phase_r <= (phase_r == PH_ADDR) ? PH_INDEX : PH_DATA;
                            if (rw_r == `HRSP_I2C_READ) begin
                                sda_oe_r <= ~regs_r[ptr_r][7];
                                tx_r     <= regs_r[ptr_r][6:0];
                                st_r     <= ST_TX;
                            end else begin
                                sda_oe_r <= 1'b0;
                                st_r     <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_r == `HRSP_TX_LAST) begin
                                sda_oe_r <= 1'b0;
                                st_r     <= ST_MACK;
                            end else begin
                                sda_oe_r <= ~tx_r[6];
                                tx_r     <= {tx_r[5:0], 1'b0};
                                bit_r    <= bit_r + 4'h1;
                            end
                        end
                    end
                    // master ack continues, no ack ends the read.
                    ST_MACK: begin
                        if (scl_rise) begin
                            ackd_r <= !sda_s;
                        end else if (scl_fall) begin
                            if (ackd_r) begin
                                bit_r    <= 4'h0;
                                sda_oe_r <= ~regs_r[ptr_r][7];
                                tx_r     <= regs_r[ptr_r][6:0];
                                st_r     <= ST_TX;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        st_r     <= ST_IDLE;
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // advance after each written byte, wrapping.
    // counter holds last access plus one.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            ptr_r <= 5'h00;
        end else if (CE_I) begin
            if (!pdn_n_s) begin
                ptr_r <= 5'h00;
            end else if (idx_set) begin
                ptr_r <= rx_r[4:0];
            end else if (w2_en || tx_load) begin
                ptr_r <= ptr_r + 5'h01;
            end
        end
    end

    logic                    w_en;
    logic [4:0]              w_idx;
    logic [7:0]              w_data;

    always_comb begin
        w_en   = w4_en || w2_en;
        w_idx  = ptr_r;
        w_data = rx_r;
        if (w4_en) begin
            w_idx  = sh4_r[11:7];
            w_data = {sh4_r[6:0], sdi_s};
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < `HRSP_NUM_REGS; i++) begin
                regs_r[i] <= reg_default(i);
            end
        end else if (CE_I) begin
            if (!pdn_n_s) begin
                for (int i = 0; i < `HRSP_NUM_REGS; i++) begin
                    regs_r[i] <= reg_default(i);
                end
            end else if (w_en) begin
                regs_r[w_idx] <= w_data;
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_WR_O   <= 1'b0;
            REG_IDX_O  <= 5'h00;
            REG_DATA_O <= 8'h00;
        end else if (CE_I) begin
            REG_WR_O <= w_en && pdn_n_s;
            if (w_en) begin
                REG_IDX_O  <= w_idx;
                REG_DATA_O <= w_data;
            end
        end else begin
            REG_WR_O <= 1'b0;
        end
    end

    // Open drain: the line is only ever pulled low.
    assign SDA_O                   = 1'b0;
    assign SDA_OE_O                = sda_oe_r;
    assign CONTROL_SERIAL_OUT_O    = control_serial_out_r;
    assign CONTROL_SERIAL_OUT_OE_O = control_serial_out_oe_r;

    a_mode_no_sda: assert property (
        @(posedge MCLK_I) disable iff (RST_I) !mode_r |-> !sda_oe_r && st_r == ST_IDLE)
        else $error("two-wire port active in four-wire mode");

    a_dir_read_only: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        $rose(control_serial_out_oe_r) |-> $past(sh4_r[5]) == `HRSP_DIR_READ && !mode_r)
        else $error("serial output enabled on a write frame");

    a_out_on_fall: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        $changed(control_serial_out_r) |-> $past(fall4))
        else $error("serial output changed off a falling edge");

    a_write_commit: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        w4_en && CE_I |=> REG_WR_O && REG_IDX_O == $past(sh4_r[11:7]) &&
        cnt4_r == `HRSP_FRAME_BITS)
        else $error("four-wire write not committed on sixteenth edge");

    a_release_cs: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        cs_n_s && CE_I |=> !control_serial_out_oe_r)
        else $error("serial output still driven after select high");

    a_pdn_default: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        !pdn_n_s && CE_I |=> regs_r[0] == `HRSP_DEF_00 && regs_r[4] == `HRSP_DEF_04)
        else $error("registers not at defaults in power-down");

    a_start_frame: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        start_ev && CE_I |=> st_r == ST_RX && bit_r == 4'h0 && phase_r == PH_ADDR)
        else $error("start did not open a frame");

    a_ack_held: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        st_r == ST_ACK |-> sda_oe_r)
        else $error("acknowledge not driven");

    a_ptr_step: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        w2_en && CE_I |=> ptr_r == $past(ptr_r) + 5'h01 && REG_WR_O)
        else $error("address counter did not advance after write");

    a_read_step: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        tx_load && CE_I && pdn_n_s |=> ptr_r == $past(ptr_r) + 5'h01 && st_r == ST_TX)
        else $error("address counter did not advance after read load");

    a_mack_free: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        st_r == ST_MACK |-> !sda_oe_r)
        else $error("line driven during master acknowledge");

    a_nomatch_idle: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        byte_done && phase_r == PH_ADDR && !addr_hit && !start_ev && !stop_ev && CE_I
        |=> st_r == ST_IDLE && !sda_oe_r)
        else $error("unmatched address not ignored");

endmodule // hrsp_top

// ### hrsp_host.sv
/* Host master model: four-wire frames and a two-wire bus master.
   Assumes the bench resolves SDA from sda_o and the slave pull-down. */
`timescale 1ns/100ps
module hrsp_host (
    // Clock and sensed pins.
    input  wire logic clk_i,
    input  wire logic sdo_i,
    input  wire logic sda_i,
    // Driven pins.
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        {cs_n_o, sclk_o, sdi_o, scl_o, sda_o} = 5'h13;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // phase lengths are set here, short to keep the run brief.
    task automatic fw(input logic [15:0] f, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_o = 1'b0;
        for (int j = 0; j < 16; j++) begin
            sdi_o = f[15-j];
            w(4);
            if (j > 7) rd = {rd[6:0], sdo_i};
            sclk_o = 1'b1;
            w(4);
            sclk_o = 1'b0;
        end
        w(4);
        cs_n_o = 1'b1;
        w(8);
    endtask
    task automatic p(input logic c, input logic d);
        scl_o = c;
        sda_o = d;
        w(4);
    endtask
    task automatic xb(input logic [8:0] t, output logic [8:0] r);
        r = 9'h000;
        for (int i = 8; i >= 0; i--) begin
            p(1'b0, sda_o);
            p(1'b0, t[i]);
            p(1'b1, t[i]);
            p(1'b1, t[i]);
            r = {r[7:0], sda_i};
        end
    endtask
    task automatic st();
        p(1'b0, sda_o);
        p(1'b0, 1'b1);
        p(1'b1, 1'b1);
        p(1'b1, 1'b0);
    endtask
    task automatic sp();
        p(1'b0, sda_o);
        p(1'b0, 1'b0);
        p(1'b1, 1'b0);
        p(1'b1, 1'b1);
    endtask
endmodule // hrsp_host

// ### hrsp_top_tb.sv
/* Self-checking bench for the host register serial port.
   Assumes the host model hrsp_host and a pulled-up SDA wire. */
`timescale 1ns/100ps
module hrsp_top_tb;
    logic        clk, rst, style, pd_n, cs_n, sclk, sdi, scl, h_sda;
    logic        sdo, sdo_oe, sda_oe, wr, sda_d, ce, cad_hi, cad_lo;
    logic [4:0]  idx;
    logic [7:0]  dat, rd;
    logic [8:0]  r;
    logic [12:0] wrq[$];
    int          errors, checked;
    wire         sda_w = h_sda & (~sda_oe | sda_d);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    hrsp_top u_hrsp_top (
        .MCLK_I(clk), .RST_I(rst), .CE_I(ce),
        .BUS_STYLE_SELECT_I(style), .POWER_DOWN_LOW_N_I(pd_n),
        .DEV_ADDR_STRAP_HI_I(cad_hi), .DEV_ADDR_STRAP_LO_I(cad_lo),
        .CHIP_SELECT_LOW_N_I(cs_n), .CONTROL_SHIFT_CLOCK_I(sclk),
        .CONTROL_SERIAL_IN_I(sdi), .CONTROL_SERIAL_OUT_O(sdo),
        .CONTROL_SERIAL_OUT_OE_O(sdo_oe), .SCL_I(scl), .SDA_I(sda_w),
        .SDA_O(sda_d), .SDA_OE_O(sda_oe), .REG_WR_O(wr), .REG_IDX_O(idx),
        .REG_DATA_O(dat)
    );
    hrsp_host u_hrsp_host (
        .clk_i(clk), .sdo_i(sdo_oe ? sdo : ~sdo), .sda_i(sda_w), .cs_n_o(cs_n),
        .sclk_o(sclk), .sdi_o(sdi), .scl_o(scl), .sda_o(h_sda)
    );
    always @(posedge clk) begin
        if (wr === 1'b1) wrq.push_back({idx, dat});
    end
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_wr(input logic [12:0] exp);
        logic [12:0] g;
        g = 'x;
        if (wrq.size() > 0) g = wrq.pop_front();
        chk(g, exp);
    endtask
    task automatic close_out();
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic rdk(input logic [4:0] a, input logic [7:0] e);
        u_hrsp_host.fw({2'h0, 1'b0, a, 8'h00}, rd);
        chk({5'h00, rd}, {5'h00, e});
        chk({12'h000, sdo_oe}, 13'h0000);
    endtask
    task automatic t_fw_write();
        u_hrsp_host.fw({2'h0, 1'b1, 5'h05, 8'hA5}, rd);
        chk_wr({5'h05, 8'hA5});
        rdk(5'h05, 8'hA5);
        u_hrsp_host.fw({2'h2, 1'b1, 5'h06, 8'h5A}, rd);
        chk(13'(wrq.size()), 13'h0000);
        rdk(5'h06, 8'h00);
    endtask
    task automatic power_cycle(input logic s);
        pd_n = 1'b0;
        style = s;
        u_hrsp_host.w(6);
        pd_n = 1'b1;
        u_hrsp_host.w(6);
    endtask
    task automatic ak(input logic [7:0] b, input logic e);
        u_hrsp_host.xb({b, 1'b1}, r);
        chk({12'h000, r[0]}, {12'h000, e});
    endtask
    task automatic rr(input logic [4:0] a, input logic [7:0] e);
        u_hrsp_host.st();
        ak(8'h24, 1'b0);
        ak({3'h0, a}, 1'b0);
        u_hrsp_host.st();
        ak(8'h25, 1'b0);
        u_hrsp_host.xb(9'h1FF, r);
        u_hrsp_host.sp();
        chk({5'h00, r[8:1]}, {5'h00, e});
    endtask
    task automatic t_i2c_mode();
        power_cycle(1'b1);
        u_hrsp_host.fw({2'h0, 1'b1, 5'h03, 8'h77}, rd);
        u_hrsp_host.st();
        ak(8'h26, 1'b1);
        ak(8'h24, 1'b1);
        u_hrsp_host.sp();
        {cad_hi, cad_lo} = 2'b01;
        u_hrsp_host.st();
        ak(8'h22, 1'b0);
        u_hrsp_host.sp();
        {cad_hi, cad_lo} = 2'b10;
        chk(13'(wrq.size()), 13'h0000);
    endtask
    task automatic t_ce_freeze();
        ce = 1'b0;
        u_hrsp_host.fw({2'h0, 1'b1, 5'h07, 8'h3C}, rd);
        ce = 1'b1;
        u_hrsp_host.w(4);
        chk(13'(wrq.size()), 13'h0000);
        rdk(5'h07, 8'h00);
    endtask
    task automatic t_i2c_write();
        u_hrsp_host.st();
        ak(8'h24, 1'b0);
        ak(8'hFF, 1'b0);
        ak(8'h11, 1'b0);
        ak(8'h22, 1'b0);
        u_hrsp_host.sp();
        chk_wr({5'h1F, 8'h11});
        chk_wr({5'h00, 8'h22});
    endtask
    task automatic t_i2c_read();
        u_hrsp_host.st();
        ak(8'h25, 1'b0);
        u_hrsp_host.xb(9'h1FE, r);
        chk({5'h00, r[8:1]}, 13'h006A);
        u_hrsp_host.xb(9'h1FF, r);
        chk({5'h00, r[8:1]}, 13'h0088);
        u_hrsp_host.sp();
        chk({12'h000, sda_oe}, 13'h0000);
    endtask
    initial begin
        {rst, style, pd_n} = 3'b101;
        {ce, cad_hi, cad_lo} = 3'b110;
        errors = 0;
        checked = 0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        u_hrsp_host.w(6);
        rdk(5'h00, 8'h43);  // first default
        rdk(5'h04, 8'hEE);  // another default
        t_fw_write();       // write and refusal
        power_cycle(1'b0);  // power-down pulse
        rdk(5'h05, 8'h00);  // register restored
        t_ce_freeze();      // frozen clock enable
        t_i2c_mode();       // mode and address
        t_i2c_write();      // burst write
        t_i2c_read();       // current read
        rr(5'h04, 8'hEE);   // indexed read
        rr(5'h00, 8'h22);   // wrapped byte
        close_out();
    end
    initial begin
        #200000;
        errors++;
        close_out();
    end
endmodule // hrsp_top_tb
